// >>> core/spss_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spss_consts.svh"
module spss_top #(
  parameter int AW = $clog2(`SPSS_PAGE_BYTES / 4)
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // External pins
  input  wire logic               ext_reset_in_n,
  input  wire logic               program_enable_n,
  input  wire logic               time_sync_pin_n,
  input  wire logic               uart_rx_act,
  // Activity demand
  input  wire logic               cpu_busy,
  input  wire logic               periph_busy,
  // Configuration flash read port
  output var  logic [AW-1:0]      cfg_addr,
  input  wire logic [31:0]        cfg_data,
  // Power and mode controls
  output var  logic               relax_osc_en,
  output var  logic               lf_osc_en,
  output var  logic               lf_timer_en,
  output var  logic               cpu_clk_en,
  output var  logic               periph_en,
  output var  logic               emul_mode,
  output var  logic               min_power,
  output var  logic               boot_run,
  output var  logic [31:0]        io_dir,
  output var  spss_pkg::spss_state_type state
);
  import spss_pkg::*;

  localparam int POR_CYC  = `SPSS_POR_CYC;
  localparam int BOOT_CYC = `SPSS_BOOT_CYC;
  localparam int CW       = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin synchronizer and edge
  logic rst_pin_s;
  logic rst_pin_prev_q, rst_pin_prev_d;
  logic rst_fall;

  spss_sync u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (ext_reset_in_n),
    .sync_out (rst_pin_s)
  );

  always_comb begin
    rst_pin_prev_d = rst_pin_s;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) rst_pin_prev_q <= 1'h1;
    else        rst_pin_prev_q <= rst_pin_prev_d;
  end

  // Edge is taken only on the synchronized level
  assign rst_fall = rst_pin_prev_q & ~rst_pin_s; // [R12] [R2]

  ////////////////////////////////////////////////////////////////////////////
  // Configuration page loader
  logic load_start;
  logic load_done;
  logic [AW-1:0] ld_addr;
  logic [31:0]   ld_dir;

  spss_cfg_loader #(
    .HW_WORDS (`SPSS_HW_WORDS),
    .AW       (AW)
  ) u_loader (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .start   (load_start),
    .done    (load_done),
    .rd_addr (ld_addr),
    .rd_data (cfg_data),
    .io_dir  (ld_dir)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Main state machine
  spss_state_type st_q, st_d;
  logic [CW-1:0]  cnt_q, cnt_d;
  logic           wake;

  // Pin activity wakes doze without the processor
  assign wake = ~time_sync_pin_n | uart_rx_act; // [R10]

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    load_start = 1'h0;
    unique case (st_q)
      SPSS_POR: begin
        if (cnt_q == CW'(POR_CYC - 1)) begin
          st_d       = SPSS_LOAD; // [R2]
          load_start = 1'h1;
          cnt_d      = '0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      SPSS_LOAD: begin
        if (load_done) st_d = SPSS_DECIDE; // [R1]
      end
      SPSS_DECIDE: begin
        if (!rst_pin_s && !program_enable_n) st_d = SPSS_EMUL;  // [R3]
        else if (!rst_pin_s)                 st_d = SPSS_MINPWR; // [R4]
        else begin
          st_d  = SPSS_BOOT; // [R5]
          cnt_d = '0;
        end
      end
      SPSS_EMUL: begin
        // Leaves only when reset pin is released; reboot follows
        if (rst_pin_s) begin
          st_d  = SPSS_BOOT; // [R6]
          cnt_d = '0;
        end
      end
      SPSS_MINPWR: begin
        if (rst_pin_s) begin
          st_d  = SPSS_BOOT; // [R4] [R5]
          cnt_d = '0;
        end
      end
      SPSS_BOOT: begin
        if (cnt_q == CW'(BOOT_CYC - 1)) st_d = SPSS_RUN; // [R5]
        else cnt_d = cnt_q + CW'(1);
      end
      SPSS_RUN: begin
        if (!cpu_busy) st_d = periph_busy ? SPSS_IDLE : SPSS_DOZE; // [R7]
      end
      SPSS_IDLE: begin
        if (cpu_busy)                st_d = SPSS_RUN;  // [R8]
        else if (!periph_busy && !wake) st_d = SPSS_DOZE; // [R9]
      end
      SPSS_DOZE: begin
        if (cpu_busy)                 st_d = SPSS_RUN;  // [R10]
        else if (periph_busy || wake) st_d = SPSS_IDLE; // [R9] [R10]
      end
      default: st_d = SPSS_POR;
    endcase
    // Synchronized reset edge restarts start-up from any state except power-on and loading
    if (rst_fall && st_q != SPSS_POR && st_q != SPSS_LOAD) begin
      st_d       = SPSS_LOAD; // [R2]
      load_start = 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q  <= SPSS_POR;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; mode levels decoded from next state, address and directions taken from the loader
  logic relax_q, lf_q, lft_q, cpu_q, per_q, emu_q, minp_q, boot_q;
  logic relax_d, lf_d, lft_d, cpu_d, per_d, emu_d, minp_d, boot_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [31:0]   dir_q, dir_d;

  // Fast oscillator stops only in doze and minimum energy
  function automatic logic fast_osc_on(input spss_state_type s);
    return !(s inside {SPSS_DOZE, SPSS_MINPWR});
  endfunction : fast_osc_on

  // Peripheral clocks are granted only in the two awake operating states
  function automatic logic awake_op(input spss_state_type s);
    return s inside {SPSS_RUN, SPSS_IDLE};
  endfunction : awake_op

  // Decoding from the next state lets every level switch on the same edge as state
  always_comb begin
    relax_d = fast_osc_on(st_d);                         // [R8] [R11]
    lf_d    = (st_d != SPSS_MINPWR);                     // [R11]
    lft_d   = (st_d != SPSS_MINPWR);                     // [R10] [R11]
    cpu_d   = (st_d == SPSS_RUN) || (st_d == SPSS_BOOT); // [R8]
    per_d   = awake_op(st_d) && periph_busy;             // [R8]
    emu_d   = (st_d == SPSS_EMUL);                       // [R6]
    minp_d  = (st_d == SPSS_MINPWR);                     // [R4]
    boot_d  = (st_d == SPSS_BOOT);                       // [R5]
    addr_d  = ld_addr;
    dir_d   = ld_dir;                                    // [R2]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      relax_q <= 1'h1;
      lf_q    <= 1'h1;
      lft_q   <= 1'h1;
      cpu_q   <= 1'h0;
      per_q   <= 1'h0;
      emu_q   <= 1'h0;
      minp_q  <= 1'h0;
      boot_q  <= 1'h0;
      addr_q  <= '0;
      dir_q   <= 32'h0000_0000;
    end else begin
      relax_q <= relax_d;
      lf_q    <= lf_d;
      lft_q   <= lft_d;
      cpu_q   <= cpu_d;
      per_q   <= per_d;
      emu_q   <= emu_d;
      minp_q  <= minp_d;
      boot_q  <= boot_d;
      addr_q  <= addr_d;
      dir_q   <= dir_d;
    end
  end

  assign relax_osc_en = relax_q;
  assign lf_osc_en    = lf_q;
  assign lf_timer_en  = lft_q;
  assign cpu_clk_en   = cpu_q;
  assign periph_en    = per_q;
  assign emul_mode    = emu_q;
  assign min_power    = minp_q;
  assign boot_run     = boot_q;
  assign cfg_addr     = addr_q;
  assign io_dir       = dir_q;
  assign state        = st_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Boot cycles are counted apart from the state counter, so a wrong
  // terminal count in the state machine cannot hide behind itself
  logic [CW-1:0] boot_seen_q, boot_seen_d;

  always_comb begin
    boot_seen_d = (st_q == SPSS_BOOT) ? boot_seen_q + CW'(1) : '0;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) boot_seen_q <= '0;
    else        boot_seen_q <= boot_seen_d;
  end

  sequence boot_done_s;
    st_q == SPSS_BOOT ##1 st_q == SPSS_RUN;
  endsequence
  sequence decide_emul_s;
    st_q == SPSS_DECIDE && !rst_pin_s && !program_enable_n && !rst_fall;
  endsequence
  sequence decide_min_s;
    st_q == SPSS_DECIDE && !rst_pin_s && program_enable_n && !rst_fall;
  endsequence

  emul_entry_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
    decide_emul_s |=> st_q == SPSS_EMUL && emul_mode)
    else $error("emulation not entered");
  minpwr_entry_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    decide_min_s |=> st_q == SPSS_MINPWR && min_power && !relax_osc_en)
    else $error("minimum energy not entered");
  minpwr_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    st_q == SPSS_MINPWR && !rst_pin_s && !rst_fall |=> st_q == SPSS_MINPWR)
    else $error("left minimum energy early");
  boot_len_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
    boot_done_s |-> boot_seen_q == CW'(BOOT_CYC))
    else $error("boot too short");
  emul_stop_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
    emul_mode |-> !cpu_clk_en && !periph_en)
    else $error("normal operation during emulation");
  doze_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
    st_q != SPSS_DOZE ##1 st_q == SPSS_DOZE |-> !$past(cpu_busy) && !$past(periph_busy))
    else $error("doze entered while busy");
  doze_wake_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    st_q == SPSS_DOZE && wake && !rst_fall |=> st_q inside {SPSS_IDLE, SPSS_RUN})
    else $error("doze did not wake");
  doze_lf_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
    st_q == SPSS_DOZE ##1 st_q == SPSS_DOZE |-> lf_osc_en && lf_timer_en && !relax_osc_en)
    else $error("doze clocks wrong");
  sync_edge_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    $fell(ext_reset_in_n) ##1 !ext_reset_in_n [*2] |-> !rst_pin_s)
    else $error("reset pin not synchronized in two stages");
  load_first_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    st_q == SPSS_LOAD |=> st_q inside {SPSS_LOAD, SPSS_DECIDE})
    else $error("decision before configuration loaded");

  // Further guards on start-up order, clocks and retention
  load_done_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    st_q == SPSS_LOAD ##1 st_q == SPSS_DECIDE |-> $past(load_done))
    else $error("decision taken before page walk finished");
  sync_lag_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    $fell(ext_reset_in_n) |-> rst_pin_s ##1 rst_pin_s)
    else $error("reset pin passed synchronizer too early");
  run_from_boot_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
    $rose(st_q == SPSS_RUN) |-> $past(st_q) inside {SPSS_BOOT, SPSS_IDLE, SPSS_DOZE})
    else $error("active state entered without boot");
  emul_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
    st_q == SPSS_EMUL && !rst_pin_s && !rst_fall |=> st_q == SPSS_EMUL && emul_mode)
    else $error("left emulation while reset held");
  active_osc_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    awake_op(st_q) |-> relax_osc_en && (cpu_clk_en == (st_q == SPSS_RUN)))
    else $error("active state clocks wrong");
  doze_keep_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    st_q == SPSS_DOZE |-> $stable(io_dir) && lf_timer_en)
    else $error("doze lost state or timekeeping");
endmodule : spss_top
`default_nettype wire

// >>> core/spss_consts.svh
// Contract
// [R1] Start-up configuration sits in one 2kB flash page: hardware and board structures.
// [R2] Start-up begins after power-on reset or synchronized reset falling edge; load page.
// [R3] During loading, reset and program-enable both asserted selects serial-flash emulation; code samples both in SPSS_DECIDE, after loading ends.
// [R4] Reset asserted without program-enable holds minimum energy until reset releases.
// [R5] Reset released outside emulation runs boot sequence, then enters active state.
// [R6] Emulation suspends normal operation and lets a programmer write internal flash.
// [R7] Operation cycles CPU-run, CPU-idle and doze, choosing lowest adequate power.
// [R8] Active runs relaxation oscillator, enables peripherals on demand, CPU may sleep.
// [R9] Doze only when all peripherals and CPU idle; peripherals move states themselves.
// [R10] Doze retains state, keeps time, wakes promptly on pin activity.
// [R11] Doze keeps 32.768kHz oscillator and its timers, may stop fast oscillator.
// [R12] External reset passes a two-stage synchronizer before any start-up decision.
`ifndef SPSS_CONSTS_SVH
`define SPSS_CONSTS_SVH
// Configuration page size in bytes
`define SPSS_PAGE_BYTES     2048
// Hardware structure occupies the first words of the page
`define SPSS_HW_WORDS       16
// Power-on reset settle time, ns, and boot time, ns
`define SPSS_POR_NS         1000
`define SPSS_BOOT_NS        4000
`define SPSS_CLK_NS         40
// Least times round up to whole cycles
`define SPSS_POR_CYC        ((`SPSS_POR_NS + `SPSS_CLK_NS - 1) / `SPSS_CLK_NS)
`define SPSS_BOOT_CYC       ((`SPSS_BOOT_NS + `SPSS_CLK_NS - 1) / `SPSS_CLK_NS)
`endif

// >>> core/spss_pkg.sv
`default_nettype none
package spss_pkg;
  typedef enum logic [8:0] {
    SPSS_POR     = 9'h001,
    SPSS_LOAD    = 9'h002,
    SPSS_DECIDE  = 9'h004,
    SPSS_EMUL    = 9'h008,
    SPSS_MINPWR  = 9'h010,
    SPSS_BOOT    = 9'h020,
    SPSS_RUN     = 9'h040,
    SPSS_IDLE    = 9'h080,
    SPSS_DOZE    = 9'h100
  } spss_state_type;
endpackage : spss_pkg
`default_nettype wire

// >>> core/spss_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spss_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronized level out
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // First stage is read only by the second; reset value is deasserted high
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= 1'h1;
      sync_q <= 1'h1;
    end else begin
      meta_q <= meta_d; // [R12]
      sync_q <= sync_d; // [R12]
    end
  end

  assign sync_out = sync_q;
endmodule : spss_sync
`default_nettype wire

// >>> core/spss_cfg_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "spss_consts.svh"
module spss_cfg_loader #(
  parameter int HW_WORDS = `SPSS_HW_WORDS,
  parameter int AW       = 9
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Control
  input  wire logic          start,
  output var  logic          done,
  // Flash read port, one 32-bit word per cycle
  output var  logic [AW-1:0] rd_addr,
  input  wire logic [31:0]   rd_data,
  // Loaded I/O direction word
  output var  logic [31:0]   io_dir
);
  logic [AW-1:0] cnt_q, cnt_d;
  logic          busy_q, busy_d;
  logic          done_q, done_d;
  logic [31:0]   dir_q, dir_d;

  // Walk the hardware structure; word 0 carries I/O directions [R1]
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'h0;
    dir_d  = dir_q;
    if (start && !busy_q) begin
      busy_d = 1'h1;
      cnt_d  = '0;
    end else if (busy_q) begin
      if (cnt_q == AW'(1)) dir_d = rd_data; // Data lags address one cycle [R2]
      if (cnt_q == AW'(HW_WORDS)) begin
        busy_d = 1'h0;
        done_d = 1'h1;
      end else begin
        cnt_d = cnt_q + AW'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'h0;
      done_q <= 1'h0;
      dir_q  <= 32'h0000_0000; // All inputs until page read, limits leakage
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      dir_q  <= dir_d;
    end
  end

  assign rd_addr = cnt_q;
  assign done    = done_q;
  assign io_dir  = dir_q;
endmodule : spss_cfg_loader
`default_nettype wire

// >>> dv/spss_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spss_host_model (
  // Clock
  input  wire logic        mclk,
  // Reset source and programmer pins
  output var  logic        ext_reset_in_n,
  output var  logic        program_enable_n,
  // Configuration page read port
  input  wire logic [8:0]  cfg_addr,
  output var  logic [31:0] cfg_data
);
  // One 2kB page of 32-bit words
  logic [31:0] page [512];

  ////////////////////////////////////////////////////////////////////////////
  // Page answers combinationally from the registered address, valid in the same cycle
  assign cfg_data = page[cfg_addr];

  // Pins idle released; enable has a pull-up so released means high
  initial begin
    ext_reset_in_n   = 1'b1;
    program_enable_n = 1'b1;
    foreach (page[i]) page[i] = ~i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins move only at the falling edge, away from sampling
  task automatic pins(input logic rst, input logic pen);
    @(negedge mclk);
    ext_reset_in_n   = rst;
    program_enable_n = pen;
  endtask : pins
endmodule : spss_host_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "spss_consts.svh"
module testbench;
  import spss_pkg::*;
  // Design signals
  logic           mclk;
  logic           rst_n;
  logic           ext_reset_in_n;
  logic           program_enable_n;
  logic           time_sync_pin_n;
  logic           uart_rx_act;
  logic           cpu_busy;
  logic           periph_busy;
  logic [8:0]     cfg_addr;
  logic [31:0]    cfg_data;
  logic           relax_osc_en;
  logic           lf_osc_en;
  logic           lf_timer_en;
  logic           cpu_clk_en;
  logic           periph_en;
  logic           emul_mode;
  logic           min_power;
  logic           boot_run;
  logic [31:0]    io_dir;
  spss_state_type state;
  // Bench bookkeeping
  int             n_errors;
  int             checked;
  integer         seed;
  logic [31:0]    v;
  spss_state_type exp;

  spss_top uut (
    .mclk(mclk), .rst_n(rst_n), .ext_reset_in_n(ext_reset_in_n),
    .program_enable_n(program_enable_n), .time_sync_pin_n(time_sync_pin_n),
    .uart_rx_act(uart_rx_act), .cpu_busy(cpu_busy), .periph_busy(periph_busy),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .relax_osc_en(relax_osc_en),
    .lf_osc_en(lf_osc_en), .lf_timer_en(lf_timer_en), .cpu_clk_en(cpu_clk_en),
    .periph_en(periph_en), .emul_mode(emul_mode), .min_power(min_power),
    .boot_run(boot_run), .io_dir(io_dir), .state(state)
  );

  spss_host_model pm (
    .mclk(mclk), .ext_reset_in_n(ext_reset_in_n),
    .program_enable_n(program_enable_n), .cfg_addr(cfg_addr), .cfg_data(cfg_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main flow or a spent wait
  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] xp);
    checked++;
    if (seen !== xp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, xp, seen);
    end
  endtask : chk

  // Bounded wait; looks a little after the edge so updates have landed
  task automatic wait_st(input spss_state_type s, input int lim);
    int k;
    k = 0;
    while (state !== s && k < lim) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (state !== s) begin
      chk("wait state", state, s);
      end_of_test();
    end
  endtask : wait_st

  // Boot must run its full length before the active state
  task automatic boot_seq();
    int n;
    n = 0;
    wait_st(SPSS_BOOT, 4);
    chk("boot_run", boot_run, 1'b1);
    while (state === SPSS_BOOT && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("boot len", n >= `SPSS_BOOT_CYC - 1 && n <= `SPSS_BOOT_CYC + 1, 1'b1);
    if (n >= 300) end_of_test();
    chk("active", state, SPSS_RUN);
    chk("mode off", {emul_mode, min_power}, 2'h0);
  endtask : boot_seq

  // Reset pin falls; decision must wait for the synchronizer
  task automatic start_up(input logic pen, input spss_state_type s);
    pm.pins(1'b0, pen);
    repeat (2) @(posedge mclk);
    #1;
    chk("sync lag", state === SPSS_LOAD, 1'b0);
    wait_st(SPSS_LOAD, 4);
    wait_st(SPSS_DECIDE, 40);
    wait_st(s, 4);
  endtask : start_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    n_errors = 0;
    checked = 0;
    seed = 32'h7686A027;
    rst_n = 1'b0;
    time_sync_pin_n = 1'b1;
    uart_rx_act = 1'b0;
    cpu_busy = 1'b1;
    periph_busy = 1'b0;
    repeat (3) @(negedge mclk);
    pm.page[0] = $random(seed);
    chk("por", state, SPSS_POR);
    chk("io_dir rst", io_dir, 32'h0);
    rst_n = 1'b1;
    wait_st(SPSS_LOAD, 40);
    wait_st(SPSS_DECIDE, 40);
    chk("cfg_addr", cfg_addr, `SPSS_HW_WORDS);
    boot_seq();
    chk("io_dir", io_dir, pm.page[0]);
    // Random demand; settled state must be the cheapest adequate one
    repeat (40) begin
      @(negedge mclk);
      v = $random(seed);
      cpu_busy = v[0];
      periph_busy = v[1] & v[2];
      uart_rx_act = v[3] & v[4];
      time_sync_pin_n = ~(v[5] & v[6]);
      exp = cpu_busy ? SPSS_RUN : (periph_busy | uart_rx_act | ~time_sync_pin_n) ?
            SPSS_IDLE : SPSS_DOZE;
      repeat (6) @(posedge mclk);
      #1;
      chk("op state", state, exp);
      chk("cpu_clk", cpu_clk_en, exp == SPSS_RUN);
      chk("relax", relax_osc_en, exp != SPSS_DOZE);
      chk("lf", {lf_osc_en, lf_timer_en}, 2'h3);
      chk("periph_en", periph_en, periph_busy);
      chk("retain", io_dir, pm.page[0]);
    end
    @(negedge mclk);
    cpu_busy = 1'b1;
    uart_rx_act = 1'b0;
    time_sync_pin_n = 1'b1;
    // Programming path, then release into boot
    start_up(1'b0, SPSS_EMUL);
    chk("emul", emul_mode, 1'b1);
    chk("emul cpu", cpu_clk_en, 1'b0);
    repeat (20) @(posedge mclk);
    #1;
    chk("emul hold", state, SPSS_EMUL);
    pm.pins(1'b1, 1'b1);
    boot_seq();
    // Minimum-energy hold while reset stays low
    start_up(1'b1, SPSS_MINPWR);
    chk("min_power", min_power, 1'b1);
    chk("min osc", {relax_osc_en, lf_osc_en}, 2'h0);
    repeat (50) @(posedge mclk);
    #1;
    chk("min hold", state, SPSS_MINPWR);
    pm.pins(1'b1, 1'b1);
    boot_seq();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
